// ===== shared/ura_dec_if.sv
// Address decode carrier between map logic and its decoder
`timescale 1ns/1ps
interface ura_dec_if;
    import ura_pkg::*;
    logic [ADDR_W-1:0] addr;
    logic [NUM_BLK-1:0] busy;
    logic reserved;
    logic busy_hit;
    logic sel_ver;
    logic sel_s1;
    logic sel_s2;
    logic [DATA_W-1:0] wmask;
    modport dec (input addr, input busy, output reserved, output busy_hit,
        output sel_ver, output sel_s1, output sel_s2, output wmask);
    modport user (output addr, output busy, input reserved,
        input busy_hit, input sel_ver, input sel_s1, input sel_s2,
        input wmask);
endinterface

// ===== shared/ura_pkg.sv
// Constants and types shared by the user register map access logic
package ura_pkg;
    // ------------------------------------------------------------
    // Widths and address span
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int NUM_BLK = 4;
    localparam logic [7:0] USER_LAST = 8'h98;
    localparam int MAP_WORDS = 153;
    localparam logic [7:0] RSV_LO = 8'h2C;
    localparam logic [7:0] RSV_HI = 8'h2F;
    localparam logic [7:0] RSV_SOLO = 8'h46;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_VERSION = 8'h00;
    localparam logic [7:0] OFS_CHAIN = 8'h01;
    localparam logic [7:0] OFS_SUM1 = 8'h02;
    localparam logic [7:0] OFS_SUM2 = 8'h03;
    localparam logic [7:0] OFS_CFG1 = 8'h14;
    localparam logic [7:0] OFS_CFG2 = 8'h15;
    // ------------------------------------------------------------
    // Field layouts: stored bits, spare bits, alert positions
    // ------------------------------------------------------------
    localparam logic [15:0] CHAIN_MASK = 16'h83FF;
    localparam logic [15:0] SUM1_MASK = 16'hFFBF;
    localparam logic [15:0] SUM2_MASK = 16'h0001;
    localparam logic [15:0] CFG1_MASK = 16'hFFFF;
    localparam logic [15:0] CFG2_MASK = 16'hE077;
    localparam logic [15:0] FULL_MASK = 16'hFFFF;
    localparam logic [15:0] NO_MASK = 16'h0000;
    localparam logic [15:0] CFG1_SPARE = 16'h0CF0;
    localparam logic [15:0] CFG2_SPARE = 16'h0004;
    localparam int SUM1_PEC_BIT = 5;
    localparam int SUM1_INTRFC_BIT = 4;
    localparam int SUM2_RJCT_BIT = 0;
    localparam logic [15:0] ZERO_WORD = 16'h0000;
    // ------------------------------------------------------------
    // Register blocks (first and last address of each)
    // ------------------------------------------------------------
    localparam logic [7:0] BLK_FIRST [NUM_BLK] =
        '{8'h00, 8'h14, 8'h19, 8'h30};
    localparam logic [7:0] BLK_LAST [NUM_BLK] =
        '{8'h13, 8'h18, 8'h2B, 8'h98};
    // Identity fields, values arbitrary
    localparam logic [11:0] MODEL_ID = 12'h5A5;
    localparam logic [3:0] REVISION_ID = 4'h1;
    typedef enum logic {URA_IDLE, URA_READ} ura_state_t;
endpackage

// ===== src/ura_addr_dec.sv
// Address decoder: reserved space, register blocks, write masks
`timescale 1ns/1ps
module ura_addr_dec
    import ura_pkg::*;
(
    ura_dec_if.dec d
);
    logic [NUM_BLK-1:0] blk_hit;
    wire out_of_span = d.addr > USER_LAST;
    wire in_hole = (d.addr >= RSV_LO && d.addr <= RSV_HI)
        || d.addr == RSV_SOLO;
    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    assign d.reserved = out_of_span | in_hole;
    genvar g;
    generate
        for (g = 0; g < NUM_BLK; g++)
        begin : g_blk
            assign blk_hit[g] = d.addr >= BLK_FIRST[g]
                && d.addr <= BLK_LAST[g] && d.busy[g];
        end
    endgenerate
    assign d.busy_hit = |blk_hit;
    assign d.sel_ver = d.addr == OFS_VERSION;
    assign d.sel_s1 = d.addr == OFS_SUM1;
    assign d.sel_s2 = d.addr == OFS_SUM2;
    // Unused bits never stored, spare bits are
    assign d.wmask = d.reserved ? NO_MASK :
        d.sel_ver ? NO_MASK :
        d.addr == OFS_CHAIN ? CHAIN_MASK :
        d.sel_s1 ? SUM1_MASK :
        d.sel_s2 ? SUM2_MASK :
        d.addr == OFS_CFG1 ? CFG1_MASK :
        d.addr == OFS_CFG2 ? CFG2_MASK : FULL_MASK;
endmodule // ura_addr_dec

// ===== src/ura_register_map.sv
// User register map with access policy and block readback
// Overview of operation
// - Protocol-violating transactions are rejected and flagged in alerts.
// - An errored transaction is discarded whole, reserved address or not.
// - User registers decode only within addresses 0x00 to 0x98.
// - Addresses 0x2C-0x2F and 0x46 are reserved, without storage.
// - Addresses 0x99 to 0xFF are reserved, without storage.
// - A clean access to a reserved address raises no error.
// - Reserved writes are dropped; reserved reads return all zeros.
// - Block readback returns zero for reserved addresses, skipping none.
// - Packet checks cover all sixteen data bits, unused ones included.
// - Unused bits ignore writes and read as zero.
// - Spare fields of both config words store and read back, no effect.
// - A register block refuses changes while an internal process uses it.
// - A write to a busy register is ignored and sets write_refused_alert.
`timescale 1ns/1ps
module ura_register_map
    import ura_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic REQ_VALID,
    input wire logic REQ_WRITE,
    input wire logic [ADDR_W-1:0] REQ_ADDR,
    input wire logic [DATA_W-1:0] REQ_WDATA,
    input wire logic [ADDR_W-1:0] REQ_COUNT,
    input wire logic REQ_PEC_ERR,
    input wire logic REQ_FRAME_ERR,
    input wire logic [NUM_BLK-1:0] BLK_BUSY,
    input wire logic [DATA_W-1:0] ALERT_EVT,
    output logic REQ_READY,
    output logic WR_DONE,
    output logic RD_VALID,
    output logic [ADDR_W-1:0] RD_ADDR,
    output logic [DATA_W-1:0] RD_DATA,
    output logic [DATA_W-1:0] CFG1_Q,
    output logic [DATA_W-1:0] CFG2_Q
);
    ura_dec_if dec ();
    ura_addr_dec u_dec (.d(dec));

    ura_state_t state_r, state_nxt;
    logic [DATA_W-1:0] mem_r [MAP_WORDS];
    logic [DATA_W-1:0] sum1_r, sum1_nxt, sum2_r, sum2_nxt;
    logic [ADDR_W-1:0] rd_addr_r, rd_left_r;
    logic req_ready_r, wr_done_r, rd_valid_r;
    logic [ADDR_W-1:0] rd_addr_out_r;
    logic [DATA_W-1:0] rd_data_r, cfg1_r, cfg2_r;

    // ------------------------------------------------------------
    // Transaction classification
    // ------------------------------------------------------------
    wire reading = state_r == URA_READ;
    wire req_take = REQ_VALID & req_ready_r;
    // Upstream checks cover the full word, so any error drops it all
    wire proto_err = REQ_PEC_ERR | REQ_FRAME_ERR;
    wire good = req_take & ~proto_err;
    wire good_wr = good & REQ_WRITE & ~dec.reserved;
    wire wr_ok = good_wr & ~dec.busy_hit;
    wire wr_rej = good_wr & dec.busy_hit;
    wire rd_start = good & ~REQ_WRITE;
    wire rd_last = reading && rd_left_r == '0;
    wire [DATA_W-1:0] wbits = REQ_WDATA & dec.wmask;
    wire [7:0] mem_idx = dec.reserved ? OFS_VERSION : dec.addr;

    assign dec.addr = reading ? rd_addr_r : REQ_ADDR;
    assign dec.busy = BLK_BUSY;

    // ------------------------------------------------------------
    // Readback word selection
    // ------------------------------------------------------------
    wire [DATA_W-1:0] rdata = dec.reserved ? ZERO_WORD :
        dec.sel_ver ? {MODEL_ID, REVISION_ID} :
        dec.sel_s1 ? sum1_r :
        dec.sel_s2 ? sum2_r : mem_r[mem_idx];

    // ------------------------------------------------------------
    // Alert words: hardware set wins over host clear (write 1 clears)
    // ------------------------------------------------------------
    wire s1_clr = wr_ok & dec.sel_s1;
    wire s2_clr = wr_ok & dec.sel_s2;
    wire [DATA_W-1:0] s1_set = (ALERT_EVT & SUM1_MASK)
        | (DATA_W'(req_take & REQ_PEC_ERR) << SUM1_PEC_BIT)
        | (DATA_W'(req_take & REQ_FRAME_ERR) << SUM1_INTRFC_BIT);
    wire [DATA_W-1:0] s2_set = DATA_W'(wr_rej) << SUM2_RJCT_BIT;

    always_comb
    begin
        sum1_nxt = ((sum1_r & ~(s1_clr ? wbits : ZERO_WORD)) | s1_set)
            & SUM1_MASK;
        sum2_nxt = ((sum2_r & ~(s2_clr ? wbits : ZERO_WORD)) | s2_set)
            & SUM2_MASK;
    end

    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            URA_IDLE: if (rd_start) state_nxt = URA_READ;
            URA_READ: if (rd_last) state_nxt = URA_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // Sequencing
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            state_r <= URA_IDLE;
            sum1_r <= ZERO_WORD;
            sum2_r <= ZERO_WORD;
            rd_addr_r <= '0;
            rd_left_r <= '0;
            req_ready_r <= 1'b1;
        end
        else
        begin
            state_r <= state_nxt;
            sum1_r <= sum1_nxt;
            sum2_r <= sum2_nxt;
            // No address is skipped; wraps from 0xFF to 0x00
            rd_addr_r <= rd_start ? REQ_ADDR : rd_addr_r + 8'h01;
            rd_left_r <= rd_start ? REQ_COUNT : rd_left_r - 8'h01;
            req_ready_r <= state_nxt == URA_IDLE;
        end
    end

    // Storage; reserved and busy targets never reach it
    always_ff @(posedge CORE_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            for (int i = 0; i < MAP_WORDS; i++)
                mem_r[i] <= ZERO_WORD;
        end
        else if (wr_ok && !dec.sel_s1 && !dec.sel_s2)
        begin
            mem_r[mem_idx] <= wbits;
        end
    end

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            wr_done_r <= 1'b0;
            rd_valid_r <= 1'b0;
            rd_addr_out_r <= '0;
            rd_data_r <= ZERO_WORD;
            cfg1_r <= ZERO_WORD;
            cfg2_r <= ZERO_WORD;
        end
        else
        begin
            // Busy rejects still answer; reserved writes stay silent
            wr_done_r <= wr_ok | wr_rej;
            rd_valid_r <= reading;
            rd_addr_out_r <= rd_addr_r;
            rd_data_r <= rdata;
            // Spare bits are held back so they steer nothing
            cfg1_r <= mem_r[OFS_CFG1] & ~CFG1_SPARE;
            cfg2_r <= mem_r[OFS_CFG2] & ~CFG2_SPARE;
        end
    end

    assign REQ_READY = req_ready_r;
    assign WR_DONE = wr_done_r;
    assign RD_VALID = rd_valid_r;
    assign RD_ADDR = rd_addr_out_r;
    assign RD_DATA = rd_data_r;
    assign CFG1_Q = cfg1_r;
    assign CFG2_Q = cfg2_r;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_proto_flag;
        @(posedge CORE_CLK) disable iff (!RST_N)
        req_take && REQ_PEC_ERR |=> sum1_r[SUM1_PEC_BIT];
    endproperty
    a_proto_flag: assert property (p_proto_flag)
        else $error("PEC error not flagged");

    property p_proto_drop;
        @(posedge CORE_CLK) disable iff (!RST_N)
        req_take && proto_err |=> !wr_done_r && !reading;
    endproperty
    a_proto_drop: assert property (p_proto_drop)
        else $error("errored transaction acted on");

    property p_rsv_zero;
        @(posedge CORE_CLK) disable iff (!RST_N)
        reading && dec.reserved |=> rd_valid_r && rd_data_r == ZERO_WORD;
    endproperty
    a_rsv_zero: assert property (p_rsv_zero)
        else $error("reserved read not zero");

    property p_span;
        @(posedge CORE_CLK) disable iff (!RST_N)
        rd_valid_r && rd_addr_out_r > USER_LAST |-> rd_data_r == ZERO_WORD;
    endproperty
    a_span: assert property (p_span)
        else $error("data above user span");

    property p_no_skip;
        @(posedge CORE_CLK) disable iff (!RST_N)
        rd_valid_r && $past(rd_valid_r)
            |-> rd_addr_out_r == $past(rd_addr_out_r) + 8'h01;
    endproperty
    a_no_skip: assert property (p_no_skip)
        else $error("readback skipped an address");

    property p_rsv_silent;
        @(posedge CORE_CLK) disable iff (!RST_N)
        good && REQ_WRITE && dec.reserved
            |=> !wr_done_r && $stable(sum1_r) [*1];
    endproperty
    a_rsv_silent: assert property (p_rsv_silent)
        else $error("reserved write answered or flagged");

    property p_busy_rej;
        @(posedge CORE_CLK) disable iff (!RST_N)
        wr_rej && REQ_ADDR == OFS_CFG1
            |=> sum2_r[SUM2_RJCT_BIT] ##1 $stable(cfg1_r);
    endproperty
    a_busy_rej: assert property (p_busy_rej)
        else $error("busy write not refused");

    property p_rjct_hold;
        @(posedge CORE_CLK) disable iff (!RST_N)
        sum2_r[SUM2_RJCT_BIT] && !s2_clr |=> sum2_r[SUM2_RJCT_BIT];
    endproperty
    a_rjct_hold: assert property (p_rjct_hold)
        else $error("refusal alert lost");

    property p_unused_zero;
        @(posedge CORE_CLK) disable iff (!RST_N)
        rd_valid_r && rd_addr_out_r == OFS_CFG2
            |-> (rd_data_r & ~CFG2_MASK) == ZERO_WORD;
    endproperty
    a_unused_zero: assert property (p_unused_zero)
        else $error("unused bits read nonzero");

    c_block_read: cover property (@(posedge CORE_CLK) disable iff (!RST_N)
        rd_valid_r && rd_addr_out_r == RSV_SOLO ##1 rd_valid_r);
    c_busy_reject: cover property (@(posedge CORE_CLK)
        disable iff (!RST_N) wr_rej);
    c_pec_drop: cover property (@(posedge CORE_CLK)
        disable iff (!RST_N) req_take && REQ_PEC_ERR && REQ_WRITE);
endmodule // ura_register_map

// ===== verif/tb.sv
// Self-checking bench for the user register map access policy
`timescale 1ns/1ps
module tb;
    import ura_pkg::*;
    logic CORE_CLK, RST_N, valid, write, pec_err, frame_err;
    logic ready, wr_done, rd_valid, done;
    logic [ADDR_W-1:0] addr, count, rd_addr;
    logic [DATA_W-1:0] wdata, rd_data, cfg1_q, cfg2_q, ALERT_EVT;
    logic [NUM_BLK-1:0] BLK_BUSY;
    int n_errors, checked, cycles;
    ura_register_map i_dut (.CORE_CLK(CORE_CLK), .RST_N(RST_N),
        .REQ_VALID(valid), .REQ_WRITE(write), .REQ_ADDR(addr),
        .REQ_WDATA(wdata), .REQ_COUNT(count), .REQ_PEC_ERR(pec_err),
        .REQ_FRAME_ERR(frame_err), .BLK_BUSY(BLK_BUSY),
        .ALERT_EVT(ALERT_EVT), .REQ_READY(ready), .WR_DONE(wr_done),
        .RD_VALID(rd_valid), .RD_ADDR(rd_addr), .RD_DATA(rd_data),
        .CFG1_Q(cfg1_q), .CFG2_Q(cfg2_q));
    ura_host i_host (.clk(CORE_CLK), .valid(valid), .write(write),
        .addr(addr), .wdata(wdata), .count(count), .pec_err(pec_err),
        .frame_err(frame_err), .ready(ready), .done(wr_done),
        .rd_valid(rd_valid), .rd_addr(rd_addr), .rd_data(rd_data));
    // ----
    // Compare and access helpers
    // ----
    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic check_word(input logic [15:0] got, input logic [15:0] e);
        checked++;
        if (got !== e)
        begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h",
                $time, got, e);
        end
    endtask
    task automatic check_bit(input logic got, input logic e);
        checked++;
        if (got !== e)
        begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h",
                $time, got, e);
        end
    endtask
    task automatic wr_chk(input logic [7:0] a, input logic [15:0] d,
        input logic e);
        i_host.wr(a, d, 1'b0, 1'b0, done);
        check_bit(done, e);
    endtask
    // Readback must hand over exactly count plus one words
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] c);
        i_host.rd(a, c);
        check_word(16'(i_host.rd_q.size()), {8'h00, c} + 16'h0001);
        // Requests are taken again once the last word has gone out
        check_bit(ready, 1'b1);
    endtask
    task automatic word_at(input int k, input logic [7:0] a,
        input logic [15:0] e);
        check_word(i_host.rd_q[k], e);
        check_word({8'h00, i_host.ra_q[k]}, {8'h00, a});
    endtask
    initial
    begin
        CORE_CLK = 1'b0;
        forever #4 CORE_CLK = ~CORE_CLK;
    end
    // Whole sequence needs well under a thousand cycles
    initial
    begin
        cycles = 0;
        forever
        begin
            @(posedge CORE_CLK);
            cycles++;
            if (cycles >= 5000)
            begin
                n_errors++;
                summarize();
            end
        end
    end
    // ----
    // Test sequence
    // ----
    initial
    begin
        n_errors = 0;
        checked = 0;
        RST_N = 1'b0;
        BLK_BUSY = 4'h0;
        ALERT_EVT = 16'h0000;
        repeat (8) @(posedge CORE_CLK);
        @(negedge CORE_CLK);
        RST_N = 1'b1;
        rd_chk(8'h00, 8'h03);
        word_at(0, 8'h00, {MODEL_ID, REVISION_ID});
        for (int k = 1; k < 4; k++) word_at(k, 8'(k), ZERO_WORD);
        wr_chk(8'h00, 16'hFFFF, 1'b1);
        wr_chk(8'h01, 16'hFFFF, 1'b1);
        wr_chk(8'h14, 16'hFFFF, 1'b1);
        wr_chk(8'h15, 16'hFFFF, 1'b1);
        rd_chk(8'h00, 8'h01);
        word_at(0, 8'h00, {MODEL_ID, REVISION_ID});
        word_at(1, 8'h01, CHAIN_MASK);
        rd_chk(8'h14, 8'h01);
        word_at(0, 8'h14, CFG1_MASK);
        word_at(1, 8'h15, CFG2_MASK);
        check_word(cfg1_q, CFG1_MASK & ~CFG1_SPARE);
        check_word(cfg2_q, CFG2_MASK & ~CFG2_SPARE);
        wr_chk(8'h2B, 16'h1234, 1'b1);
        wr_chk(8'h30, 16'h5678, 1'b1);
        wr_chk(8'h2C, 16'hFFFF, 1'b0);
        wr_chk(8'h46, 16'hFFFF, 1'b0);
        wr_chk(8'h98, 16'hABCD, 1'b1);
        wr_chk(8'h99, 16'hFFFF, 1'b0);
        rd_chk(8'h2B, 8'h05);
        word_at(0, 8'h2B, 16'h1234);
        for (int k = 1; k < 5; k++)
            word_at(k, 8'(8'h2B + k), ZERO_WORD);
        word_at(5, 8'h30, 16'h5678);
        rd_chk(8'h46, 8'h00);
        word_at(0, 8'h46, ZERO_WORD);
        // Long readback runs through the top reserved span and wraps
        rd_chk(8'h98, 8'h68);
        word_at(0, 8'h98, 16'hABCD);
        for (int k = 1; k < 104; k++)
            word_at(k, 8'(8'h98 + k), ZERO_WORD);
        word_at(104, 8'h00, {MODEL_ID, REVISION_ID});
        rd_chk(8'h02, 8'h01);
        word_at(0, 8'h02, ZERO_WORD);
        word_at(1, 8'h03, ZERO_WORD);
        i_host.wr(8'h2B, 16'h0BAD, 1'b1, 1'b0, done);
        check_bit(done, 1'b0);
        i_host.wr(8'h2C, 16'h0BAD, 1'b0, 1'b1, done);
        check_bit(done, 1'b0);
        rd_chk(8'h2B, 8'h00);
        word_at(0, 8'h2B, 16'h1234);
        rd_chk(8'h02, 8'h00);
        word_at(0, 8'h02, 16'h0030);
        wr_chk(8'h02, 16'h0030, 1'b1);
        BLK_BUSY = 4'h2;
        wr_chk(8'h14, 16'h0000, 1'b1);
        BLK_BUSY = 4'h0;
        ALERT_EVT = 16'h8040;
        @(negedge CORE_CLK);
        ALERT_EVT = 16'h0000;
        rd_chk(8'h02, 8'h01);
        word_at(0, 8'h02, 16'h8000);
        word_at(1, 8'h03, 16'h0001);
        rd_chk(8'h14, 8'h00);
        word_at(0, 8'h14, CFG1_MASK);
        check_word(cfg1_q, CFG1_MASK & ~CFG1_SPARE);
        wr_chk(8'h03, 16'h0001, 1'b1);
        rd_chk(8'h03, 8'h00);
        word_at(0, 8'h03, ZERO_WORD);
        summarize();
    end
endmodule // tb

// ===== verif/ura_host.sv
// Host model: issues register requests and gathers readback words
`timescale 1ns/1ps
module ura_host
    import ura_pkg::*;
(
    input wire logic clk,
    output logic valid,
    output logic write,
    output logic [ADDR_W-1:0] addr,
    output logic [DATA_W-1:0] wdata,
    output logic [ADDR_W-1:0] count,
    output logic pec_err,
    output logic frame_err,
    input wire logic ready,
    input wire logic done,
    input wire logic rd_valid,
    input wire logic [ADDR_W-1:0] rd_addr,
    input wire logic [DATA_W-1:0] rd_data
);
    logic [DATA_W-1:0] rd_q [$];
    logic [ADDR_W-1:0] ra_q [$];
    initial
    begin
        valid = 1'b0;
        write = 1'b0;
        addr = 8'h00;
        wdata = 16'h0000;
        count = 8'h00;
        pec_err = 1'b0;
        frame_err = 1'b0;
    end
    // Presents a request at a falling edge and holds it until taken
    task automatic put(input logic w, input logic [7:0] a,
        input logic [15:0] d, input logic [7:0] c, input logic p,
        input logic f);
        int n;
        @(negedge clk);
        valid = 1'b1;
        write = w;
        addr = a;
        wdata = d;
        count = c;
        pec_err = p;
        frame_err = f;
        n = 0;
        while (ready !== 1'b1 && n < 100)
        begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        valid = 1'b0;
        // Released address, data and count carry inverted junk; error flags clear, write keeps its value
        addr = ~addr;
        wdata = ~wdata;
        count = ~count;
        pec_err = 1'b0;
        frame_err = 1'b0;
    endtask
    // Reserved or busy places are written only when a test asks
    task automatic wr(input logic [7:0] a, input logic [15:0] d,
        input logic p, input logic f, output logic ok);
        put(1'b1, a, d, 8'h00, p, f);
        // The answer pulse stands from the taking edge to the next one
        ok = done;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] c);
        int n;
        rd_q.delete();
        ra_q.delete();
        put(1'b0, a, 16'h0000, c, 1'b0, 1'b0);
        n = 0;
        while (rd_q.size() <= int'(c) && n < 300)
        begin
            if (rd_valid === 1'b1)
            begin
                rd_q.push_back(rd_data);
                ra_q.push_back(rd_addr);
            end
            @(negedge clk);
            n++;
        end
    endtask
endmodule // ura_host
